// >>> instr_exec_pkg.sv
package instr_exec_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_ACC = 8'h00;
	localparam logic [7:0] OFS_PTR0 = 8'h04;
	localparam logic [7:0] OFS_PTR1 = 8'h08;
	localparam logic [7:0] OFS_IRQ_CTRL = 8'h0c;
	localparam logic [7:0] OFS_PWR_CTRL = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_PC = 8'h18;
	localparam logic [7:0] OFS_STACK = 8'h1c;

	// ****************************************
	// field positions and widths
	// ****************************************
	localparam int IRQ_ENABLE_BIT = 7;
	localparam int SOFT_RESET_FLAG_BIT = 2;
	localparam int PC_W = 15;
	localparam int LEVEL_W = 4;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
	localparam logic [7:0] PWR_CTRL_RST = 8'h04;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [14:0] PC_RST = 15'h0000;
	localparam logic [3:0] LEVEL_RST = 4'h0;

	// ****************************************
	// instruction codes and address modes
	// ****************************************
	localparam logic [2:0] OP_NOP = 3'h0;
	localparam logic [2:0] OP_STORE_ACC_INDIRECT = 3'h1;
	localparam logic [2:0] OP_STORE_ACC_RELATIVE = 3'h2;
	localparam logic [2:0] OP_SOFT_RESET = 3'h3;
	localparam logic [2:0] OP_RETURN_FROM_IRQ = 3'h4;
	localparam logic [2:0] OP_RETURN_WITH_LITERAL = 3'h5;
	localparam logic [2:0] OP_RETURN = 3'h6;
	localparam logic [1:0] MODE_PRE_INC = 2'h0;
	localparam logic [1:0] MODE_PRE_DEC = 2'h1;
	localparam logic [1:0] MODE_POST_INC = 2'h2;
	localparam logic [1:0] MODE_POST_DEC = 2'h3;

	typedef enum logic {
		ST_RUN = 1'b0,
		ST_SECOND = 1'b1
	} exec_state_e;

endpackage

// >>> instr_exec.sv
`timescale 1ns/10ps

// What this block does
// - indirect store writes accumulator to pointer address
// - mode code picks pre/post increment/decrement
// - relative form: pointer plus offset, pointer kept
// - pointer wraps modulo 16 bits
// - store never touches status flags
// - soft reset resets all but power control, clears flag
// - interrupt return pops stack, two cycles
// - interrupt return sets global interrupt enable
// - literal return loads accumulator and pc, two cycles
// - plain return loads pc, flags unchanged
module instr_exec (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction issue
	input wire logic instr_valid,
	input wire logic [2:0] instr_op,
	input wire logic instr_ptr_sel,
	input wire logic [1:0] instr_mode,
	input wire logic [5:0] instr_offset,
	input wire logic [7:0] instr_literal,
	output logic instr_ready,
	// data memory write port
	output logic mem_wr_en,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	// hardware stack
	input wire logic [14:0] top_of_stack_entry,
	input wire logic stack_push,
	output logic stack_pop,
	output logic [3:0] stack_level,
	// core state
	output logic [14:0] pc_value,
	output logic global_irq_enable,
	output logic soft_reset_req
);

	// ****************************************
	// state
	// ****************************************
	instr_exec_pkg::exec_state_e state_reg, state_next;
	logic sreset_reg;
	logic [7:0] acc_reg, acc_next;
	logic [15:0] ptr0_reg, ptr0_next, ptr1_reg, ptr1_next;
	logic [7:0] irq_control_reg, irq_next;
	logic [7:0] power_control_reg, pwr_next;
	logic [7:0] status_reg, status_next;
	logic [14:0] pc_reg, pc_next;
	logic [3:0] level_reg, level_next;
	logic mem_wr_reg;
	logic [15:0] mem_addr_reg, mem_addr_next;
	logic [7:0] mem_wdata_reg;
	logic pop_reg;
	logic [31:0] prdata_reg, rd_mux;

	// wraps at both ends of the 16-bit range
	function automatic logic [15:0] ptr_step(input logic [15:0] ptr, input logic dec);
		ptr_step = dec ? ptr - 16'h0001 : ptr + 16'h0001;
	endfunction

	// ****************************************
	// instruction decode
	// ****************************************
	wire take = instr_valid & instr_ready;
	wire do_store = take & (instr_op == instr_exec_pkg::OP_STORE_ACC_INDIRECT);
	wire do_rel = take & (instr_op == instr_exec_pkg::OP_STORE_ACC_RELATIVE);
	wire do_sreset = take & (instr_op == instr_exec_pkg::OP_SOFT_RESET);
	wire do_irq_ret = take & (instr_op == instr_exec_pkg::OP_RETURN_FROM_IRQ);
	wire do_retlit = take & (instr_op == instr_exec_pkg::OP_RETURN_WITH_LITERAL);
	wire do_ret = take & (instr_op == instr_exec_pkg::OP_RETURN);
	wire do_pop = do_irq_ret | do_retlit | do_ret;

	// ****************************************
	// pointer and address arithmetic
	// ****************************************
	wire [15:0] sel_ptr = instr_ptr_sel ? ptr1_reg : ptr0_reg;
	wire [15:0] stepped_ptr = ptr_step(sel_ptr, instr_mode[0]);
	wire [15:0] rel_addr = sel_ptr + {{10{instr_offset[5]}}, instr_offset};
	wire post_mode = instr_mode[1];
	assign mem_addr_next = do_rel ? rel_addr : (post_mode ? sel_ptr : stepped_ptr);
	wire upd0 = do_store & ~instr_ptr_sel;
	wire upd1 = do_store & instr_ptr_sel;

	// ****************************************
	// apb decode
	// ****************************************
	wire hit_acc = (paddr == instr_exec_pkg::OFS_ACC);
	wire hit_ptr0 = (paddr == instr_exec_pkg::OFS_PTR0);
	wire hit_ptr1 = (paddr == instr_exec_pkg::OFS_PTR1);
	wire hit_irq = (paddr == instr_exec_pkg::OFS_IRQ_CTRL);
	wire hit_pwr = (paddr == instr_exec_pkg::OFS_PWR_CTRL);
	wire hit_status = (paddr == instr_exec_pkg::OFS_STATUS);
	wire hit_pc = (paddr == instr_exec_pkg::OFS_PC);
	wire hit_stack = (paddr == instr_exec_pkg::OFS_STACK);
	wire mapped = hit_acc | hit_ptr0 | hit_ptr1 | hit_irq | hit_pwr | hit_status | hit_pc
		| hit_stack;
	wire apb_wr = psel & penable & pwrite & mapped;
	assign rd_mux = hit_acc ? {24'h000000, acc_reg} :
		hit_ptr0 ? {16'h0000, ptr0_reg} :
		hit_ptr1 ? {16'h0000, ptr1_reg} :
		hit_irq ? {24'h000000, irq_control_reg} :
		hit_pwr ? {24'h000000, power_control_reg} :
		hit_status ? {24'h000000, status_reg} :
		hit_pc ? {17'h00000, pc_reg} :
		hit_stack ? {28'h0000000, level_reg} : 32'h00000000;

	// ****************************************
	// next values: soft reset, then instruction, then software
	// ****************************************
	assign acc_next = sreset_reg ? instr_exec_pkg::ACC_RST :
		do_retlit ? instr_literal :
		(apb_wr & hit_acc) ? pwdata[7:0] : acc_reg;
	assign ptr0_next = sreset_reg ? instr_exec_pkg::PTR_RST :
		upd0 ? stepped_ptr :
		(apb_wr & hit_ptr0) ? pwdata[15:0] : ptr0_reg;
	assign ptr1_next = sreset_reg ? instr_exec_pkg::PTR_RST :
		upd1 ? stepped_ptr :
		(apb_wr & hit_ptr1) ? pwdata[15:0] : ptr1_reg;
	assign irq_next = sreset_reg ? instr_exec_pkg::IRQ_CTRL_RST :
		do_irq_ret ? ((apb_wr & hit_irq) ? pwdata[7:0] : irq_control_reg)
			| (8'h01 << instr_exec_pkg::IRQ_ENABLE_BIT) :
		(apb_wr & hit_irq) ? pwdata[7:0] : irq_control_reg;
	// the flag is cleared when the soft reset is issued; power control is not reloaded by it
	assign pwr_next = do_sreset ? power_control_reg
			& ~(8'h01 << instr_exec_pkg::SOFT_RESET_FLAG_BIT) :
		(apb_wr & hit_pwr) ? pwdata[7:0] : power_control_reg;
	// status flags: software only, no instruction but soft reset changes them
	assign status_next = sreset_reg ? instr_exec_pkg::STATUS_RST :
		(apb_wr & hit_status) ? pwdata[7:0] : status_reg;
	assign pc_next = sreset_reg ? instr_exec_pkg::PC_RST :
		do_pop ? top_of_stack_entry : pc_reg;
	assign level_next = sreset_reg ? instr_exec_pkg::LEVEL_RST :
		do_pop ? level_reg - 4'h1 :
		stack_push ? level_reg + 4'h1 : level_reg;
	// returns hold issue off for one extra cycle
	assign state_next = (sreset_reg | ~do_pop) ?
		instr_exec_pkg::ST_RUN : instr_exec_pkg::ST_SECOND;

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= instr_exec_pkg::ST_RUN;
			sreset_reg <= 1'b0;
			acc_reg <= instr_exec_pkg::ACC_RST;
			ptr0_reg <= instr_exec_pkg::PTR_RST;
			ptr1_reg <= instr_exec_pkg::PTR_RST;
			irq_control_reg <= instr_exec_pkg::IRQ_CTRL_RST;
			power_control_reg <= instr_exec_pkg::PWR_CTRL_RST;
			status_reg <= instr_exec_pkg::STATUS_RST;
			pc_reg <= instr_exec_pkg::PC_RST;
			level_reg <= instr_exec_pkg::LEVEL_RST;
		end else begin
			state_reg <= state_next;
			sreset_reg <= do_sreset;
			acc_reg <= acc_next;
			ptr0_reg <= ptr0_next;
			ptr1_reg <= ptr1_next;
			irq_control_reg <= irq_next;
			power_control_reg <= pwr_next;
			status_reg <= status_next;
			pc_reg <= pc_next;
			level_reg <= level_next;
		end
	end

	// memory write port and pop strobe, one cycle after issue
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mem_wr_reg <= 1'b0;
			mem_addr_reg <= 16'h0000;
			mem_wdata_reg <= 8'h00;
			pop_reg <= 1'b0;
		end else begin
			mem_wr_reg <= do_store | do_rel;
			mem_addr_reg <= sreset_reg ? 16'h0000 :
				((do_store | do_rel) ? mem_addr_next : mem_addr_reg);
			mem_wdata_reg <= sreset_reg ? 8'h00 :
				((do_store | do_rel) ? acc_reg : mem_wdata_reg);
			pop_reg <= do_pop;
		end
	end

	// read data is captured in the setup phase
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata_reg <= 32'h00000000;
		end else begin
			prdata_reg <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_reg;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign instr_ready = (state_reg == instr_exec_pkg::ST_RUN) & ~sreset_reg;
	assign mem_wr_en = mem_wr_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_wdata = mem_wdata_reg;
	assign stack_pop = pop_reg;
	assign stack_level = level_reg;
	assign pc_value = pc_reg;
	assign global_irq_enable = irq_control_reg[instr_exec_pkg::IRQ_ENABLE_BIT];
	assign soft_reset_req = sreset_reg;
	assign prdata = prdata_reg;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	property p_store_data;
		(do_store | do_rel) |=> mem_wr_en && mem_wdata == $past(acc_reg);
	endproperty
	a_store_data: assert property (p_store_data) else $error("store data wrong");

	property p_post_addr;
		(do_store && instr_mode[1]) |=> mem_addr == $past(sel_ptr);
	endproperty
	a_post_addr: assert property (p_post_addr) else $error("post mode address wrong");

	property p_pre_addr;
		(do_store && !instr_mode[1]) |=> mem_addr == ($past(instr_ptr_sel) ? ptr1_reg : ptr0_reg);
	endproperty
	a_pre_addr: assert property (p_pre_addr) else $error("pre mode address wrong");

	property p_rel_keep;
		(do_rel && !apb_wr) |=> $stable(ptr0_reg) && $stable(ptr1_reg)
			&& mem_addr == $past(rel_addr);
	endproperty
	a_rel_keep: assert property (p_rel_keep) else $error("relative form moved pointer");

	property p_wrap;
		(upd0 && ptr0_reg == 16'hffff && instr_mode == instr_exec_pkg::MODE_POST_INC)
			|=> ptr0_reg == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

	property p_flags;
		(do_store | do_rel | do_ret) && !apb_wr |=> $stable(status_reg);
	endproperty
	a_flags: assert property (p_flags) else $error("status flags changed");

	property p_sreset;
		do_sreset |=> soft_reset_req
			&& !power_control_reg[instr_exec_pkg::SOFT_RESET_FLAG_BIT]
			##1 acc_reg == instr_exec_pkg::ACC_RST && level_reg == instr_exec_pkg::LEVEL_RST;
	endproperty
	a_sreset: assert property (p_sreset) else $error("soft reset incomplete");

	property p_two_cycles;
		do_pop |=> !instr_ready ##1 instr_ready;
	endproperty
	a_two_cycles: assert property (p_two_cycles) else $error("return not two cycles");

	property p_irq_enable;
		do_irq_ret |=> global_irq_enable;
	endproperty
	a_irq_enable: assert property (p_irq_enable) else $error("interrupts not enabled");

	property p_retlit;
		do_retlit |=> acc_reg == $past(instr_literal) && pc_value == $past(top_of_stack_entry);
	endproperty
	a_retlit: assert property (p_retlit) else $error("literal return wrong");

	property p_return_pc;
		do_ret |=> pc_value == $past(top_of_stack_entry) && stack_pop;
	endproperty
	a_return_pc: assert property (p_return_pc) else $error("return pc wrong");

	property p_pop_level;
		do_pop |=> stack_level == $past(level_reg) - 4'h1;
	endproperty
	a_pop_level: assert property (p_pop_level) else $error("stack level not stepped");

	property p_pop_pulse;
		do_pop |=> stack_pop ##1 !stack_pop;
	endproperty
	a_pop_pulse: assert property (p_pop_pulse) else $error("pop strobe not one cycle");

	c_store_pre: cover property (do_store && instr_mode == instr_exec_pkg::MODE_PRE_DEC);
	c_store_ptr1: cover property (upd1 && instr_mode == instr_exec_pkg::MODE_POST_DEC);
	c_store_rel: cover property (do_rel && instr_offset[5]);
	c_irq_ret: cover property (do_irq_ret ##2 take);
	c_sreset: cover property (do_sreset ##2 instr_ready);

endmodule

// >>> test_indirect_store_and_return_ops.sv
`timescale 1ns/10ps

module test_indirect_store_and_return_ops;

	// ****************************************
	// stimulus, observation and counters
	// ****************************************
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic instr_valid = 1'b0;
	logic [2:0] op = 3'h0;
	logic ptr_sel = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [5:0] off = 6'h00;
	logic [7:0] lit = 8'h00;
	logic [14:0] stack_top = 15'h0000;
	logic stack_push = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, instr_ready, mem_wr_en, stack_pop, irq_en, srr;
	logic [15:0] maddr;
	logic [7:0] mwdata;
	logic [3:0] lvl;
	logic [14:0] pc;
	int mismatches = 0;
	int compares = 0;

	instr_exec u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_valid(instr_valid), .instr_op(op), .instr_ptr_sel(ptr_sel),
		.instr_mode(mode), .instr_offset(off), .instr_literal(lit), .instr_ready(instr_ready),
		.mem_wr_en(mem_wr_en), .mem_addr(maddr), .mem_wdata(mwdata),
		.top_of_stack_entry(stack_top), .stack_push(stack_push), .stack_pop(stack_pop),
		.stack_level(lvl), .pc_value(pc), .global_irq_enable(irq_en), .soft_reset_req(srr));

	// 125 mhz system clock
	initial forever #4 clk_sys = ~clk_sys;

	// ****************************************
	// shared tasks
	// ****************************************
	task final_report;
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; holds the request until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			final_report;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// holds the instruction until it is taken, then lets the edge settle
	task issue(input logic [2:0] o, input logic s, input logic [1:0] m, input logic [5:0] k,
		input logic [7:0] l);
		int n;
		n = 0;
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		op <= o;
		ptr_sel <= s;
		mode <= m;
		off <= k;
		lit <= l;
		do begin
			@(posedge clk_sys);
			n++;
		end while (instr_ready !== 1'b1 && n < 20);
		if (instr_ready !== 1'b1) begin
			mismatches++;
			final_report;
		end
		instr_valid <= 1'b0;
		#1;
	endtask

	// store of the accumulator, then write port and pointer checked
	task store(input logic [2:0] o, input logic s, input logic [1:0] m, input logic [5:0] k,
		input logic [15:0] ea, input logic [15:0] ep);
		issue(o, s, m, k, 8'h00);
		chk(mem_wr_en, 32'h1);
		chk(maddr, ea);
		chk(mwdata, 32'ha5);
		apb(1'b0, s ? instr_exec_pkg::OFS_PTR1 : instr_exec_pkg::OFS_PTR0, 32'h0);
		chk(rd, ep);
	endtask

	// return of any kind: pop pulse, one blocked cycle, pc and level
	task ret(input logic [2:0] o, input logic [7:0] l, input logic [3:0] el);
		issue(o, 1'b0, 2'h0, 6'h00, l);
		chk(stack_pop, 32'h1);
		chk(instr_ready, 32'h0);
		chk(pc, stack_top);
		chk(lvl, el);
		// issue reopens after one blocked cycle, pop strobe gone
		@(posedge clk_sys);
		#1;
		chk(instr_ready, 32'h1);
		chk(stack_pop, 32'h0);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	logic [1:0] mt [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
	logic [15:0] at [5] = '{16'hffff, 16'h0000, 16'hffff, 16'hffff, 16'h0000};
	logic [15:0] pt [5] = '{16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'hffff};

	initial begin
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		// reset values and an unmapped read
		apb(1'b0, instr_exec_pkg::OFS_PWR_CTRL, 32'h0);
		chk(rd, 32'h4);
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, instr_exec_pkg::OFS_ACC, 32'ha5);
		apb(1'b1, instr_exec_pkg::OFS_PTR0, 32'hfffe);
		apb(1'b1, instr_exec_pkg::OFS_STATUS, 32'h7);
		// every address mode across both wrap points
		for (int i = 0; i < 5; i++) begin
			store(instr_exec_pkg::OP_STORE_ACC_INDIRECT, 1'b0, mt[i], 6'h00, at[i], pt[i]);
		end
		// relative offsets at both ends of the range
		apb(1'b1, instr_exec_pkg::OFS_PTR1, 32'h10);
		store(instr_exec_pkg::OP_STORE_ACC_RELATIVE, 1'b1, 2'h0, 6'h20, 16'hfff0, 16'h0010);
		store(instr_exec_pkg::OP_STORE_ACC_RELATIVE, 1'b1, 2'h0, 6'h1f, 16'h002f, 16'h0010);
		store(instr_exec_pkg::OP_STORE_ACC_INDIRECT, 1'b1, 2'h3, 6'h00, 16'h0010, 16'h000f);
		apb(1'b0, instr_exec_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h7);
		// two pushes, then each kind of return
		@(posedge clk_sys);
		stack_push <= 1'b1;
		stack_top <= 15'h1234;
		repeat (2) @(posedge clk_sys);
		stack_push <= 1'b0;
		ret(instr_exec_pkg::OP_RETURN_FROM_IRQ, 8'h00, 4'h1);
		chk(irq_en, 32'h1);
		apb(1'b0, instr_exec_pkg::OFS_IRQ_CTRL, 32'h0);
		chk(rd, 32'h80);
		@(posedge clk_sys);
		stack_top <= 15'h2abc;
		ret(instr_exec_pkg::OP_RETURN_WITH_LITERAL, 8'h3c, 4'h0);
		apb(1'b0, instr_exec_pkg::OFS_ACC, 32'h0);
		chk(rd, 32'h3c);
		@(posedge clk_sys);
		stack_top <= 15'h7fff;
		ret(instr_exec_pkg::OP_RETURN, 8'h00, 4'hf);
		apb(1'b0, instr_exec_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h7);
		// software reset clears state and clears the cause flag
		issue(instr_exec_pkg::OP_SOFT_RESET, 1'b0, 2'h0, 6'h00, 8'h00);
		chk(srr, 32'h1);
		apb(1'b0, instr_exec_pkg::OFS_PWR_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, instr_exec_pkg::OFS_ACC, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, instr_exec_pkg::OFS_PTR0, 32'h0);
		chk(rd, 32'h0);
		chk(pc, 32'h0);
		chk(irq_en, 32'h0);
		chk(maddr, 32'h0);
		chk(mwdata, 32'h0);
		final_report;
	end

endmodule
